// ### nvmacc_consts.svh
// Offsets, field positions, reset values and timing counts of the data store access unit
`ifndef NVMACC_CONSTS_SVH
`define NVMACC_CONSTS_SVH
`define NVMACC_DEPTH              128
`define NVMACC_SECTOR0            1'h0
`define NVMACC_CTRL_SECTOR        8'h01
`define NVMACC_CTRL_OFFSET        8'h40
`define NVMACC_INDEX_RESET        7'h00
`define NVMACC_BYTE_RESET         8'h00
`define NVMACC_CTRL_RESET         8'h00
`define NVMACC_BIT_RD             0
`define NVMACC_BIT_READ_PERMIT    1
`define NVMACC_BIT_WR             2
`define NVMACC_BIT_WRITE_PERMIT   3
`define NVMACC_BIT_MODE           4
`define NVMACC_BIT_ERASE_START    5
`define NVMACC_BIT_ERASE_PERMIT   6
`define NVMACC_BIT_TIME_SELECT    7
`define NVMACC_CLK_NS             20
`define NVMACC_WR_NS              2200000
`define NVMACC_WR_LONG_NS         3700000
`define NVMACC_ERASE_NS           3200000
`define NVMACC_ERASE_LONG_NS      5700000
`define NVMACC_WR_CYC             ((`NVMACC_WR_NS + `NVMACC_CLK_NS - 1) / `NVMACC_CLK_NS)
`define NVMACC_WR_LONG_CYC        ((`NVMACC_WR_LONG_NS + `NVMACC_CLK_NS - 1) / `NVMACC_CLK_NS)
`define NVMACC_ERASE_CYC          ((`NVMACC_ERASE_NS + `NVMACC_CLK_NS - 1) / `NVMACC_CLK_NS)
`define NVMACC_ERASE_LONG_CYC     ((`NVMACC_ERASE_LONG_NS + `NVMACC_CLK_NS - 1) / `NVMACC_CLK_NS)
`define NVMACC_PAGE_BYTES         16
`endif

// ### nvmacc_pkg.sv
// Types of the data store access unit
package nvmacc_pkg;
  typedef enum logic [1:0] {
    NVMACC_IDLE  = 2'b00,
    NVMACC_READ  = 2'b01,
    NVMACC_WRITE = 2'b10,
    NVMACC_ERASE = 2'b11
  } nvmacc_state_t;
endpackage

// ### nvmacc_top.sv
// Register access unit for the 128 x 8 non-volatile data store
`timescale 1ns/1ps
`include "nvmacc_consts.svh"
// Notes on behaviour
// [R1] Store holds 128 bytes, kept without power
// [R2] Store not in normal memory map
// [R3] Byte access; index, data sector 0, control 1
// [R4] Index and data registers directly read/write
// [R5] Control at sector 1, 40H, indirect only
// [R6] Software sets pointer 40H / 01H first
// [R7] Index bits 6..0 read/write, reset zero
// [R8] Index bit 7 reads zero
// [R9] Data register holds eight read/write bits
// [R10] Software never raises two start/enables together
// [R11] Software waits for erase/write completion
// [R12] Erase has byte and page mode
// [R13] Other pointers or direct access miss control
module nvmacc_top #(
  parameter int WR_CYCLES         = `NVMACC_WR_CYC,
  parameter int WR_LONG_CYCLES    = `NVMACC_WR_LONG_CYC,
  parameter int ERASE_CYCLES      = `NVMACC_ERASE_CYC,
  parameter int ERASE_LONG_CYCLES = `NVMACC_ERASE_LONG_CYC,
  parameter int PAGE_BYTES        = `NVMACC_PAGE_BYTES
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Direct special register port, sector 0
  input  wire logic       dir_wr,
  input  wire logic       dir_sel_data,
  input  wire logic [7:0] dir_wdata,
  // Indirect port through a pointer pair
  input  wire logic       ind_wr,
  input  wire logic       ind_rd,
  input  wire logic [7:0] ind_ptr_low,
  input  wire logic [7:0] ind_ptr_high,
  input  wire logic [7:0] ind_wdata,
  // Register views
  output logic [7:0]      nvm_location_index,
  output logic [7:0]      nvm_byte_value,
  output logic [7:0]      nvm_control,
  output logic [7:0]      ind_rdata,
  output logic            busy
);
  logic [7:0]                 store [0:`NVMACC_DEPTH-1];
  logic [6:0]                 location_index_bits;
  logic [7:0]                 byte_value_bits;
  logic [7:0]                 ctrl;
  nvmacc_pkg::nvmacc_state_t  state;
  logic [31:0]                count;
  logic                       ctrl_hit;
  logic [6:0]                 page_base;

  function automatic logic [6:0] page_of(input logic [6:0] idx);
    page_of = idx & ~7'(PAGE_BYTES - 1);
  endfunction

  assign ctrl_hit  = (ind_ptr_high == `NVMACC_CTRL_SECTOR)
                  && (ind_ptr_low == `NVMACC_CTRL_OFFSET); // [R5] [R13]
  assign page_base = page_of(location_index_bits);

  // Index register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      location_index_bits <= `NVMACC_INDEX_RESET; // [R7]
    end else if (dir_wr && !dir_sel_data) begin
      location_index_bits <= dir_wdata[6:0]; // [R4] [R7]
    end
  end

  // Control register, indirect only; hardware clears start bits at cycle end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl <= `NVMACC_CTRL_RESET;
    end else if (state != nvmacc_pkg::NVMACC_IDLE && count == 32'h0) begin
      ctrl[`NVMACC_BIT_RD] <= 1'b0;
      ctrl[`NVMACC_BIT_WR] <= 1'b0;
      ctrl[`NVMACC_BIT_ERASE_START] <= 1'b0;
    end else if (ind_wr && ctrl_hit && state == nvmacc_pkg::NVMACC_IDLE) begin
      ctrl <= ind_wdata; // [R5] [R13]
      ctrl[`NVMACC_BIT_RD] <= ind_wdata[`NVMACC_BIT_RD] & ctrl[`NVMACC_BIT_READ_PERMIT];
      ctrl[`NVMACC_BIT_WR] <= ind_wdata[`NVMACC_BIT_WR] & ctrl[`NVMACC_BIT_WRITE_PERMIT];
      ctrl[`NVMACC_BIT_ERASE_START] <= ind_wdata[`NVMACC_BIT_ERASE_START]
                                     & ctrl[`NVMACC_BIT_ERASE_PERMIT];
    end
  end

  // Cycle sequencer
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= nvmacc_pkg::NVMACC_IDLE;
      count <= 32'h0;
    end else begin
      unique case (state)
        nvmacc_pkg::NVMACC_IDLE: begin
          if (ctrl[`NVMACC_BIT_RD]) begin
            state <= nvmacc_pkg::NVMACC_READ;
            count <= 32'h0;
          end else if (ctrl[`NVMACC_BIT_WR]) begin
            state <= nvmacc_pkg::NVMACC_WRITE;
            count <= 32'(ctrl[`NVMACC_BIT_TIME_SELECT] ? WR_LONG_CYCLES - 1 : WR_CYCLES - 1);
          end else if (ctrl[`NVMACC_BIT_ERASE_START]) begin
            state <= nvmacc_pkg::NVMACC_ERASE;
            count <= 32'(ctrl[`NVMACC_BIT_TIME_SELECT] ? ERASE_LONG_CYCLES - 1
                                                         : ERASE_CYCLES - 1);
          end
        end
        nvmacc_pkg::NVMACC_READ,
        nvmacc_pkg::NVMACC_WRITE,
        nvmacc_pkg::NVMACC_ERASE: begin
          if (count == 32'h0) begin
            state <= nvmacc_pkg::NVMACC_IDLE;
          end else begin
            count <= count - 32'h1;
          end
        end
      endcase
    end
  end

  // Data register: software writes, read cycle loads store byte
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      byte_value_bits <= `NVMACC_BYTE_RESET;
    end else if (state == nvmacc_pkg::NVMACC_READ) begin
      byte_value_bits <= store[location_index_bits]; // [R3] [R9]
    end else if (dir_wr && dir_sel_data) begin
      byte_value_bits <= dir_wdata; // [R4] [R9]
    end
  end

  // Store array, reached only through the access registers
  always_ff @(posedge clk) begin
    if (state == nvmacc_pkg::NVMACC_WRITE && count == 32'h0) begin
      store[location_index_bits] <= byte_value_bits; // [R1] [R2] [R3]
    end else if (state == nvmacc_pkg::NVMACC_ERASE && count == 32'h0) begin
      for (int i = 0; i < `NVMACC_DEPTH; i++) begin
        if (!ctrl[`NVMACC_BIT_MODE] ? (7'(i) == location_index_bits)
            : (page_of(7'(i)) == page_base)) begin // [R12]
          store[i] <= 8'hff;
        end
      end
    end
  end

  // Register views
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      nvm_location_index <= 8'h00;
      nvm_byte_value     <= 8'h00;
      nvm_control        <= 8'h00;
      ind_rdata          <= 8'h00;
      busy               <= 1'b0;
    end else begin
      nvm_location_index <= {1'b0, location_index_bits}; // [R8]
      nvm_byte_value     <= byte_value_bits;
      nvm_control        <= ctrl;
      ind_rdata          <= (ind_rd && ctrl_hit) ? ctrl : 8'h00; // [R13]
      busy               <= (state != nvmacc_pkg::NVMACC_IDLE);
    end
  end

  property p_index_msb;
    @(posedge clk) disable iff (rst) nvm_location_index[7] == 1'b0;
  endproperty
  a_index_msb: assert property (p_index_msb) else $error("index bit 7 set"); // [R8]

  property p_index_write;
    @(posedge clk) disable iff (rst)
      (dir_wr && !dir_sel_data) |-> ##2 nvm_location_index[6:0] == $past(dir_wdata[6:0], 2);
  endproperty
  a_index_write: assert property (p_index_write) else $error("index write lost"); // [R4] [R7]

  property p_ctrl_miss;
    @(posedge clk) disable iff (rst)
      (!ctrl_hit && state == nvmacc_pkg::NVMACC_IDLE && !ctrl[`NVMACC_BIT_RD]
       && !ctrl[`NVMACC_BIT_WR] && !ctrl[`NVMACC_BIT_ERASE_START]) |=> $stable(ctrl);
  endproperty
  a_ctrl_miss: assert property (p_ctrl_miss) else $error("control changed by miss"); // [R13]

  property p_ctrl_hit;
    @(posedge clk) disable iff (rst)
      (ind_wr && ctrl_hit && state == nvmacc_pkg::NVMACC_IDLE)
      |=> ctrl[`NVMACC_BIT_MODE] == $past(ind_wdata[`NVMACC_BIT_MODE]);
  endproperty
  a_ctrl_hit: assert property (p_ctrl_hit) else $error("control write lost"); // [R5] [R12]

  property p_read_loads;
    @(posedge clk) disable iff (rst)
      state == nvmacc_pkg::NVMACC_READ |=> byte_value_bits == $past(store[location_index_bits]);
  endproperty
  a_read_loads: assert property (p_read_loads) else $error("read byte wrong"); // [R3] [R9]

  property p_data_write;
    @(posedge clk) disable iff (rst)
      (dir_wr && dir_sel_data && state != nvmacc_pkg::NVMACC_READ)
      |=> byte_value_bits == $past(dir_wdata);
  endproperty
  a_data_write: assert property (p_data_write) else $error("data write lost"); // [R9]

  property p_read_clears;
    @(posedge clk) disable iff (rst)
      state == nvmacc_pkg::NVMACC_READ |=> !ctrl[`NVMACC_BIT_RD] ##1 state == nvmacc_pkg::NVMACC_IDLE;
  endproperty
  a_read_clears: assert property (p_read_clears) else $error("read start not cleared"); // [R12]

  property p_ind_read;
    @(posedge clk) disable iff (rst)
      (ind_rd && !ctrl_hit) |=> ind_rdata == 8'h00;
  endproperty
  a_ind_read: assert property (p_ind_read) else $error("control read on miss"); // [R13]

  property p_ind_hit_read;
    @(posedge clk) disable iff (rst)
      (ind_rd && ctrl_hit) |=> ind_rdata == $past(ctrl);
  endproperty
  a_ind_hit_read: assert property (p_ind_hit_read) else $error("control read wrong"); // [R5]

  property p_write_commit;
    @(posedge clk) disable iff (rst)
      (state == nvmacc_pkg::NVMACC_WRITE && count == 32'h0)
      |=> store[$past(location_index_bits)] == $past(byte_value_bits);
  endproperty
  a_write_commit: assert property (p_write_commit) else $error("store not written"); // [R1] [R3]

  property p_page_erase;
    @(posedge clk) disable iff (rst)
      (state == nvmacc_pkg::NVMACC_ERASE && count == 32'h0 && ctrl[`NVMACC_BIT_MODE])
      |=> store[$past(page_base)] == 8'hff
          && store[$past(page_base) | 7'(PAGE_BYTES - 1)] == 8'hff;
  endproperty
  a_page_erase: assert property (p_page_erase) else $error("page not erased"); // [R12]
endmodule

// ### nvmacc_top_tb.sv
// Self-checking bench of the data store access unit
`timescale 1ns/1ps
module nvmacc_top_tb;
  logic       clk, rst, dir_wr, dir_sel_data, ind_wr, ind_rd, busy;
  logic [7:0] dir_wdata, ind_ptr_low, ind_ptr_high, ind_wdata, ind_rdata;
  logic [7:0] nvm_location_index, nvm_byte_value, nvm_control;
  int         failures, checks_done;

  nvmacc_top #(.WR_CYCLES(6), .WR_LONG_CYCLES(8), .ERASE_CYCLES(5), .ERASE_LONG_CYCLES(7),
    .PAGE_BYTES(16)) nvmacc_top_i (
    .clk(clk), .rst(rst), .dir_wr(dir_wr), .dir_sel_data(dir_sel_data),
    .dir_wdata(dir_wdata), .ind_wr(ind_wr), .ind_rd(ind_rd), .ind_ptr_low(ind_ptr_low),
    .ind_ptr_high(ind_ptr_high), .ind_wdata(ind_wdata),
    .nvm_location_index(nvm_location_index), .nvm_byte_value(nvm_byte_value),
    .nvm_control(nvm_control), .ind_rdata(ind_rdata), .busy(busy));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  // Direct sector 0 write, views settle two cycles later
  task automatic dwr(input logic sel, input logic [7:0] val);
    @(negedge clk);
    dir_sel_data = sel;
    dir_wdata    = val;
    dir_wr       = 1'b1;
    @(negedge clk);
    dir_wr = 1'b0;
    repeat (2) @(negedge clk);
  endtask

  // Indirect write through a pointer pair
  task automatic iwr(input logic [7:0] hi, input logic [7:0] lo, input logic [7:0] val);
    @(negedge clk);
    ind_ptr_high = hi;
    ind_ptr_low  = lo;
    ind_wdata    = val;
    ind_wr       = 1'b1;
    @(negedge clk);
    ind_wr = 1'b0;
    repeat (2) @(negedge clk);
  endtask

  // Indirect read, answer stands one cycle
  task automatic ird(input logic [7:0] hi, input logic [7:0] lo, input logic [7:0] exp);
    @(negedge clk);
    ind_ptr_high = hi;
    ind_ptr_low  = lo;
    ind_rd       = 1'b1;
    @(negedge clk);
    ind_rd = 1'b0;
    check(ind_rdata, exp);
  endtask

  // Bounded wait for the running cycle to end
  task automatic wait_idle();
    int n;
    repeat (3) @(negedge clk);
    for (n = 0; n < 200; n++) begin
      if (busy === 1'b0) break;
      @(negedge clk);
    end
    if (busy !== 1'b0) begin
      failures++;
      $display("[ERR] t=%0t busy stuck seen=%h expected=0", $time, busy);
      close_out();
    end
    @(negedge clk);
  endtask

  // Count the cycles that busy stands after a start, then settle
  task automatic busy_len(input logic [7:0] exp);
    int n;
    n = 0;
    while (busy === 1'b1 && n < 200) begin
      n++;
      @(negedge clk);
    end
    check(8'(n), exp);
    wait_idle();
  endtask

  initial begin
    {dir_wr, dir_sel_data, ind_wr, ind_rd} = 4'h0;
    {dir_wdata, ind_ptr_low, ind_ptr_high, ind_wdata} = 32'h0;
    failures    = 0;
    checks_done = 0;
    rst         = 1'b1;
    repeat (5) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    check(nvm_location_index, 8'h00);
    check(nvm_byte_value, 8'h00);
    check(nvm_control, 8'h00);
    $display("test reset done");
    dwr(1'b0, 8'hff);
    check(nvm_location_index, 8'h7f);
    dwr(1'b0, 8'h05);
    check(nvm_location_index, 8'h05);
    dwr(1'b1, 8'h3c);
    check(nvm_byte_value, 8'h3c);
    $display("test direct done");
    iwr(8'h00, 8'h40, 8'h02);
    check(nvm_control, 8'h00);
    iwr(8'h01, 8'h41, 8'h02);
    check(nvm_control, 8'h00);
    ird(8'h00, 8'h40, 8'h00);
    iwr(8'h01, 8'h40, 8'h01);
    check(nvm_control, 8'h00);
    iwr(8'h01, 8'h40, 8'h02);
    check(nvm_control, 8'h02);
    ird(8'h01, 8'h40, 8'h02);
    $display("test indirect done");
    iwr(8'h01, 8'h40, 8'h08);
    iwr(8'h01, 8'h40, 8'h0c);
    busy_len(8'h06);
    check(nvm_control, 8'h08);
    dwr(1'b1, 8'h00);
    iwr(8'h01, 8'h40, 8'h02);
    iwr(8'h01, 8'h40, 8'h03);
    wait_idle();
    check(nvm_byte_value, 8'h3c);
    check(nvm_control, 8'h02);
    $display("test write read done");
    iwr(8'h01, 8'h40, 8'h40);
    iwr(8'h01, 8'h40, 8'h60);
    busy_len(8'h05);
    check(nvm_control, 8'h40);
    iwr(8'h01, 8'h40, 8'h02);
    iwr(8'h01, 8'h40, 8'h03);
    wait_idle();
    check(nvm_byte_value, 8'hff);
    $display("test erase done");
    dwr(1'b0, 8'h10);
    dwr(1'b1, 8'h5a);
    iwr(8'h01, 8'h40, 8'h88);
    iwr(8'h01, 8'h40, 8'h8c);
    busy_len(8'h08);
    dwr(1'b0, 8'h20);
    iwr(8'h01, 8'h40, 8'h0c);
    busy_len(8'h06);
    dwr(1'b0, 8'h1f);
    iwr(8'h01, 8'h40, 8'h0c);
    busy_len(8'h06);
    iwr(8'h01, 8'h40, 8'hd0);
    iwr(8'h01, 8'h40, 8'hf0);
    busy_len(8'h07);
    check(nvm_control, 8'hd0);
    iwr(8'h01, 8'h40, 8'h02);
    iwr(8'h01, 8'h40, 8'h03);
    wait_idle();
    check(nvm_byte_value, 8'hff);
    dwr(1'b0, 8'h10);
    iwr(8'h01, 8'h40, 8'h03);
    wait_idle();
    check(nvm_byte_value, 8'hff);
    dwr(1'b0, 8'h20);
    iwr(8'h01, 8'h40, 8'h03);
    wait_idle();
    check(nvm_byte_value, 8'h5a);
    $display("test page erase done");
    close_out();
  end
endmodule
